/* logic/capture_pkg.sv */
// Shared constants, register map and types of the input capture channel
package capture_pkg;

    // Register indices on the plain register port (word addresses)
    localparam logic [3:0] addr_control    = 4'h0;
    localparam logic [3:0] addr_fifo       = 4'h1;
    localparam logic [3:0] addr_status     = 4'h2;
    localparam logic [3:0] addr_irq_status = 4'h3;
    localparam logic [3:0] addr_irq_mask   = 4'h4;
    localparam logic [3:0] addr_route      = 4'h5;

    // Control register field positions
    localparam int ctl_mode_lsb   = 0;   // 3 bits
    localparam int ctl_src_lsb    = 3;   // 2 bits
    localparam int ctl_first_bit  = 5;
    localparam int ctl_ithr_lsb   = 6;   // 2 bits, count minus one
    localparam int ctl_enable_bit = 8;

    // Interrupt status bit positions
    localparam int irq_thresh_bit   = 0;
    localparam int irq_edge_bit     = 1;
    localparam int irq_overflow_bit = 2;
    localparam int irq_width        = 3;

    // Reset values
    localparam logic [31:0] control_reset  = 32'h0000_0000;
    localparam logic [3:0]  route_reset    = 4'h0;
    localparam logic [2:0]  irq_mask_reset = 3'h0;

    // Prescaler last counts, one below the span
    localparam logic [3:0] div4_last  = 4'h3;
    localparam logic [3:0] div16_last = 4'hf;

    typedef enum logic [2:0] {
        mode_off     = 3'h0,
        mode_falling = 3'h1,
        mode_rising  = 3'h2,
        mode_both    = 3'h3,
        mode_first   = 3'h4,
        mode_div4    = 3'h5,
        mode_div16   = 3'h6
    } capture_mode_t;

    typedef enum logic [1:0] {
        src_first  = 2'h0,
        src_second = 2'h1,
        src_cascade = 2'h2
    } time_src_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
    } time_base_t;

endpackage

/* logic/input_capture_channel.sv */
// Input capture channel: edge detection, time base latch, FIFO, interrupts
`timescale 1ns/1ns

// Function
// - Latch selected time base on qualifying event
// - Falling mode captures every falling edge
// - Rising mode captures every rising edge
// - Both mode captures every edge
// - Wait for chosen first edge, then both
// - Divide-by-four captures every fourth rise
// - Divide-by-sixteen captures every sixteenth rise
// - Software picks either 16-bit timer
// - Cascaded timers give 32-bit capture
// - Pin event wakes sleeping or idle device
// - Capture events can raise interrupt
// - Four-entry FIFO read out in order
// - Interrupt after one to four entries
// - Edge flag usable as external interrupt
// - 4-bit route field picks input pin
module input_capture_channel #(
    parameter int PINS  = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // Register port
    input  wire capture_pkg::reg_req_t  req,
    output logic [31:0]                 rdata,
    // Candidate pins and time bases
    input  wire logic [PINS-1:0]        capture_input_pin,
    input  wire capture_pkg::time_base_t time_base,
    // Power state and outputs
    input  wire logic                   low_power,
    output logic                        wake,
    output logic                        irq
);

    initial begin
        if (PINS < 1 || PINS > 16 || DEPTH != 4) begin
            $error("input_capture_channel: unsupported parameters");
        end
    end

    logic [31:0]                control;
    logic [3:0]                 capture_route_select;
    logic [2:0]                 irq_status;
    logic [2:0]                 irq_mask;
    logic [31:0]                fifo_mem [DEPTH];
    logic [1:0]                 wr_ptr;
    logic [1:0]                 rd_ptr;
    logic [2:0]                 count;
    logic                       sync_a;
    logic                       sync_b;
    logic                       sample_prev;
    logic                       armed;
    logic [3:0]                 prescale;
    logic                       rise;
    logic                       fall;
    logic                       capture;
    logic                       push;
    logic                       pop;
    logic                       overflow_evt;
    logic                       thresh_hit;
    logic                       enable;
    logic [31:0]                stamp;
    capture_pkg::capture_mode_t mode;
    capture_pkg::time_src_t     src;

    function automatic logic is_write(input capture_pkg::reg_req_t r, input logic [3:0] a);
        is_write = r.wr && (r.addr == a);
    endfunction

    assign mode   = capture_pkg::capture_mode_t'(control[capture_pkg::ctl_mode_lsb +: 3]);
    assign src    = capture_pkg::time_src_t'(control[capture_pkg::ctl_src_lsb +: 2]);
    assign enable = control[capture_pkg::ctl_enable_bit];

    // Registers written by software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            control              <= capture_pkg::control_reset;
            capture_route_select <= capture_pkg::route_reset;
            irq_mask             <= capture_pkg::irq_mask_reset;
        end else begin
            if (is_write(req, capture_pkg::addr_control)) begin
                control <= req.wdata;
            end
            if (is_write(req, capture_pkg::addr_route)) begin
                capture_route_select <= req.wdata[3:0];
            end
            if (is_write(req, capture_pkg::addr_irq_mask)) begin
                irq_mask <= req.wdata[2:0];
            end
        end
    end

    // Two-stage synchroniser; only the second stage is looked at
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a      <= 1'b0;
            sync_b      <= 1'b0;
            sample_prev <= 1'b0;
        end else begin
            sync_a      <= (int'(capture_route_select) < PINS) ?
                           capture_input_pin[capture_route_select] : 1'b0;
            sync_b      <= sync_a;
            sample_prev <= sync_b;
        end
    end

    assign rise = sync_b && !sample_prev;
    assign fall = !sync_b && sample_prev;

    // Mode-change resets the arm flag and prescaler so a new mode starts clean
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed    <= 1'b0;
            prescale <= 4'h0;
        end else if (!enable || is_write(req, capture_pkg::addr_control)) begin
            armed    <= 1'b0;
            prescale <= 4'h0;
        end else begin
            if (mode == capture_pkg::mode_first &&
                ((control[capture_pkg::ctl_first_bit] && rise) ||
                 (!control[capture_pkg::ctl_first_bit] && fall))) begin
                armed <= 1'b1;
            end
            if (rise && (mode == capture_pkg::mode_div4 || mode == capture_pkg::mode_div16)) begin
                if ((mode == capture_pkg::mode_div4 && prescale == capture_pkg::div4_last) ||
                    prescale == capture_pkg::div16_last) begin
                    prescale <= 4'h0;
                end else begin
                    prescale <= prescale + 4'h1;
                end
            end
        end
    end

    always_comb begin
        capture = 1'b0;
        if (enable) begin
            unique case (mode)
                capture_pkg::mode_off:     capture = 1'b0;
                capture_pkg::mode_falling: capture = fall;
                capture_pkg::mode_rising:  capture = rise;
                capture_pkg::mode_both:    capture = rise || fall;
                // First qualifying edge is itself captured, then every edge
                capture_pkg::mode_first:   capture = (rise || fall) && (armed ||
                    (control[capture_pkg::ctl_first_bit] ? rise : fall));
                capture_pkg::mode_div4:    capture = rise &&
                    prescale == capture_pkg::div4_last;
                capture_pkg::mode_div16:   capture = rise &&
                    prescale == capture_pkg::div16_last;
                default:                   capture = 1'b0;
            endcase
        end
    end

    always_comb begin
        unique case (src)
            capture_pkg::src_first:   stamp = {16'h0000, time_base.first};
            capture_pkg::src_second:  stamp = {16'h0000, time_base.second};
            capture_pkg::src_cascade: stamp = {time_base.second, time_base.first};
            default:                  stamp = {16'h0000, time_base.first};
        endcase
    end

    // Full FIFO drops the new capture; a pop in the same cycle does not free room
    assign pop          = req.rd && req.addr == capture_pkg::addr_fifo && count != 3'h0;
    assign push         = capture && count != 3'(DEPTH);
    assign overflow_evt = capture && count == 3'(DEPTH);
    assign thresh_hit   = push &&
        (count + 3'h1) == {1'b0, control[capture_pkg::ctl_ithr_lsb +: 2]} + 3'h1;

    always_ff @(posedge clk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= stamp;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            count  <= 3'h0;
        end else if (!enable) begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            count  <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 2'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 2'h1;
            end
            count <= count + {2'b00, push} - {2'b00, pop};
        end
    end

    // Sticky interrupt flags: a new event wins over a write-one clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~(is_write(req, capture_pkg::addr_irq_status) ?
                           req.wdata[2:0] : 3'h0)) |
                          {overflow_evt, capture, thresh_hit};
        end
    end

    assign irq  = |(irq_status & irq_mask);
    assign wake = low_power && capture;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            unique case (req.addr)
                capture_pkg::addr_control:    rdata <= control;
                capture_pkg::addr_fifo:       rdata <= (count != 3'h0) ?
                                                       fifo_mem[rd_ptr] : 32'h0000_0000;
                capture_pkg::addr_status:     rdata <= {28'h0000000, armed, count};
                capture_pkg::addr_irq_status: rdata <= {29'h00000000, irq_status};
                capture_pkg::addr_irq_mask:   rdata <= {29'h00000000, irq_mask};
                capture_pkg::addr_route:      rdata <= {28'h0000000, capture_route_select};
                default:                      rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule

/* tb/capture_monitor.sv */
// Port checker for the input capture channel
`timescale 1ns/1ns
module capture_monitor #(
    parameter int PINS  = 16,
    parameter int DEPTH = 4
) (
    // Clock, reset, registers
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire capture_pkg::reg_req_t   req,
    input wire logic [31:0]             rdata,
    // Pins and outputs
    input wire logic [PINS-1:0]         capture_input_pin,
    input wire capture_pkg::time_base_t time_base,
    input wire logic                    low_power,
    input wire logic                    wake,
    input wire logic                    irq
);
    logic [8:0] ctl;
    logic [2:0] msk;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Shadows of written settings, so reads and outputs can be judged
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= 9'h0;
            msk <= 3'h0;
        end else if (req.wr && req.addr == capture_pkg::addr_control) begin
            ctl <= req.wdata[8:0];
        end else if (req.wr && req.addr == capture_pkg::addr_irq_mask) begin
            msk <= req.wdata[2:0];
        end
    end
    a_read_quiet: assert property (!$past(req.rd) |-> rdata == 32'h0)
        else $error("read data outside answer");
    a_unmapped_zero: assert property (req.rd && req.addr > 4'h5 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctl_readback: assert property (req.rd && req.addr == 4'h0 |=> rdata[8:0] == ctl)
        else $error("control readback");
    a_idle_empty: assert property (req.rd && req.addr == 4'h2 && !ctl[8] |=> rdata == 32'h0)
        else $error("disabled channel holds entries");
    a_wake_cause: assert property (wake |-> low_power && ctl[8] && ctl[2:0] != 3'h0)
        else $error("wake without cause");
    a_irq_masked: assert property (irq |-> msk != 3'h0)
        else $error("irq while all masked");
    a_edge_irq: assert property (wake && msk[1] && !req.wr |=> irq)
        else $error("edge flag gave no irq");
    a_mask_off: assert property (req.wr && req.addr == 4'h4 && req.wdata[2:0] == 3'h0 |=> !irq)
        else $error("irq after mask cleared");
    c_wake: cover property (wake);
    c_irq: cover property ($rose(irq));
    c_pop: cover property (req.rd && req.addr == 4'h1 ##1 rdata != 32'h0);
endmodule

bind input_capture_channel capture_monitor #(.PINS(PINS), .DEPTH(DEPTH)) capture_monitor_inst (
    .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .capture_input_pin(capture_input_pin),
    .time_base(time_base), .low_power(low_power), .wake(wake), .irq(irq));

/* tb/pin_source.sv */
// Model of the external signal on the capture input pins
`timescale 1ns/1ns
module pin_source (
    // Clock
    input wire logic   clk,
    // Pins
    output logic [15:0] pins
);
    initial pins = 16'h0;
    // Each level is held hold+1 cycles, never under one, so the sampler sees it
    task automatic flip(input int idx, input int hold);
        @(posedge clk);
        pins[idx] <= ~pins[idx];
        repeat (hold) @(posedge clk);
    endtask
endmodule

/* tb/input_capture_channel_tb.sv */
// Self-checking bench of the input capture channel
`timescale 1ns/1ns
module input_capture_channel_tb;
    logic                    clk;
    logic                    rst_b;
    capture_pkg::reg_req_t   req;
    logic [31:0]             rdata;
    logic [15:0]             pins;
    capture_pkg::time_base_t time_base;
    logic                    low_power;
    logic                    wake;
    logic                    irq;
    logic [31:0]             got;
    int                      n_fail;
    int                      comparisons;
    int                      cycles;
    int                      n_wake;

    input_capture_channel input_capture_channel_inst (.clk(clk), .rst_b(rst_b), .req(req),
        .rdata(rdata), .capture_input_pin(pins), .time_base(time_base),
        .low_power(low_power), .wake(wake), .irq(irq));
    pin_source pin_source_inst (.clk(clk), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (wake === 1'b1) n_wake++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 got = rdata;
    endtask

    function automatic capture_pkg::time_base_t tv(input int k);
        return '{16'h1000 + 16'(k), 16'h2000 + 16'(k)};
    endfunction

    task automatic s_reset();
        rd(capture_pkg::addr_control);
        chk("control", capture_pkg::control_reset, got);
        rd(capture_pkg::addr_irq_mask);
        chk("mask", 32'h0, got);
        rd(4'h9);
        chk("unmapped", 32'h0, got);
        wr(capture_pkg::addr_route, 32'ha);
        rd(capture_pkg::addr_route);
        chk("route", 32'ha, got);
        wr(capture_pkg::addr_route, 32'h0);
    endtask

    // Four toggles: rise, fall, rise, fall; hit bits mark the captured ones
    task automatic s_modes();
        logic [3:0]                  hits [4] = '{4'b1010, 4'b0101, 4'b1111, 4'b1110};
        logic [1:0]                  s;
        capture_pkg::time_base_t     t;
        for (int m = 0; m < 4; m++) begin
            s = (m == 3) ? 2'h0 : 2'(m);
            wr(capture_pkg::addr_control, {23'h0, 1'b1, 3'h0, s, 3'(m + 1)});
            for (int k = 0; k < 4; k++) begin
                @(posedge clk);
                time_base <= tv(k);
                pin_source_inst.flip(0, 6);
            end
            rd(capture_pkg::addr_status);
            chk("count", 32'($countones(hits[m])), got & 32'h7);
            for (int k = 0; k < 4; k++) begin
                t = tv(k);
                if (hits[m][k]) begin
                    rd(capture_pkg::addr_fifo);
                    chk("entry", s == 2'h2 ? {t.second, t.first} :
                        {16'h0, s == 2'h1 ? t.second : t.first}, got);
                end
            end
            rd(capture_pkg::addr_fifo);
            chk("empty pop", 32'h0, got);
        end
    endtask

    task automatic s_div(input logic [2:0] mode, input int span, input int rises);
        wr(capture_pkg::addr_control, {23'h0, 1'b1, 5'h0, mode});
        for (int r = 1; r <= rises; r++) begin
            pin_source_inst.flip(0, 4);
            pin_source_inst.flip(0, 4);
            rd(capture_pkg::addr_status);
            chk("prescaled", 32'(r / span), got & 32'h7);
        end
        wr(capture_pkg::addr_control, 32'h0);
    endtask

    task automatic pulse(input int idx, input int n);
        for (int i = 0; i < 2 * n; i++) pin_source_inst.flip(idx, 4);
    endtask

    task automatic s_irq();
        wr(capture_pkg::addr_route, 32'h5);
        // Earlier scenarios leave edge and threshold flags set; start clean
        wr(capture_pkg::addr_irq_status, 32'h7);
        wr(capture_pkg::addr_irq_mask, 32'h7);
        wr(capture_pkg::addr_control, {23'h0, 1'b1, 2'h1, 3'h0, 3'(capture_pkg::mode_rising)});
        low_power <= 1'b1;
        n_wake = 0;
        pulse(0, 1);
        chk("stray wake", 32'h0, 32'(n_wake));
        pulse(5, 1);
        #1 chk("edge irq", 32'h1, {31'h0, irq});
        chk("wake", 32'h1, 32'(n_wake));
        rd(capture_pkg::addr_irq_status);
        chk("flags one", 32'h2, got);
        wr(capture_pkg::addr_irq_status, 32'h7);
        #1 chk("cleared irq", 32'h0, {31'h0, irq});
        wr(capture_pkg::addr_irq_mask, 32'h5);
        pulse(5, 1);
        #1 chk("threshold irq", 32'h1, {31'h0, irq});
        rd(capture_pkg::addr_irq_status);
        chk("flags two", 32'h3, got);
        wr(capture_pkg::addr_irq_status, 32'h7);
        pulse(5, 3);
        rd(capture_pkg::addr_irq_status);
        chk("overflow", 32'h6, got);
        rd(capture_pkg::addr_status);
        chk("full", 32'h4, got & 32'h7);
        wr(capture_pkg::addr_irq_mask, 32'h0);
        #1 chk("masked irq", 32'h0, {31'h0, irq});
        low_power <= 1'b0;
        wr(capture_pkg::addr_control, 32'h0);
    endtask

    initial begin
        rst_b = 1'b0;
        req = '0;
        time_base = '0;
        low_power = 1'b0;
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        n_wake = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        s_reset();
        s_modes();
        s_div(capture_pkg::mode_div4, int'(capture_pkg::div4_last) + 1, 8);
        s_div(capture_pkg::mode_div16, int'(capture_pkg::div16_last) + 1, 16);
        s_irq();
        wrap_up();
    end
endmodule
